// file: core/pof_regs.svh
`ifndef POF_REGS_SVH
`define POF_REGS_SVH

// register byte offsets on the control bus
`define POF_CTRL_OFS 12'h000
`define POF_STAT_OFS 12'h004
`define POF_CTRL_RST 8'h00

// control register fields
`define POF_MODE_MSB 3
`define POF_MODE_LSB 0
`define POF_CSWAP_BIT 4
`define POF_YCSWAP_BIT 5
`define POF_NOOFF_BIT 6
`define POF_EN_BIT 7

// status register fields
`define POF_STAT_BUSY 0
`define POF_STAT_PHASE 1
`define POF_STAT_CNT_LSB 16
`define POF_STAT_CNT_MSB 31

// bus responses
`define POF_RESP_OKAY 2'h0
`define POF_RESP_SLVERR 2'h2

// luma weights, scaled by 1024
`define POF_K601_R 10'h132
`define POF_K601_G 10'h259
`define POF_K601_B 10'h075
`define POF_KSRGB_R 10'h0DA
`define POF_KSRGB_G 10'h2DC
`define POF_KSRGB_B 10'h04A

// chroma gains, scaled by 1024 (studio ones include 224/256)
`define POF_K601_U 10'h242
`define POF_K601_V 10'h2DA
`define POF_KSRGB_U 10'h228
`define POF_KSRGB_V 10'h28A
`define POF_KSTU_CB 10'h1E3
`define POF_KSTU_CR 10'h239

// rounding, offsets and ranges
`define POF_RND 32'h0000_0200
`define POF_C_OFF 32'h0000_0080
`define POF_Y_SCALE 16'h00DB
`define POF_SCL_RND 16'h0080
`define POF_Y_FLOOR 8'h10
`define POF_Y_CEIL 8'hEB
`define POF_C_FLOOR 8'h10
`define POF_C_CEIL 8'hF0
`define POF_FULL_LO 8'h00
`define POF_FULL_HI 8'hFF
`define POF_SIGN_FLIP 8'h80

`endif

// file: core/pof_pkg.sv
package pof_pkg;

  // output format selection, in the order of the control field codes
  typedef enum logic [3:0] {
    POF_YUV601,
    POF_YCC_SRGB,
    POF_YUV_SRGB,
    POF_RGB565,
    POF_RGB555,
    POF_RGB444X,
    POF_RGBX444,
    POF_BAYER10,
    POF_BAYER82
  } pof_mode_e;

  // one incoming pixel: processed colour plus raw sample
  typedef struct packed {
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
    logic [9:0] raw;
  } pof_pix_s;

endpackage

// file: core/pof_top.sv
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
// Overview of operation
// - 601 luma uses 0.299, 0.587, 0.114 weights
// - 601 chroma: scaled colour minus luma, plus 128
// - option drops the 128 chroma offset
// - studio luma scaled by 219/256 plus 16
// - studio chroma gains scaled by 224/256 plus 128
// - studio luma 16..235, chroma 16..240
// - sRGB full-range YUV weights without scaling
// - option drops 128 in sRGB full-range YUV
// - YCbCr byte order under both swap controls
// - luma/chroma swap exchanges RGB byte pair
// - chroma swap exchanges red and blue bits
// - 565 packing of red, green, blue bits
// - 555 packing with leading zero bit
// - 444 packings with four zero bits
// - Bayer ten wires: upper eight plus two
// - Bayer 8+2: high byte, then low bits
`include "pof_regs.svh"

module pof_top
  import pof_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire pof_pix_s pix_i,
  input wire logic pix_valid,
  output logic pix_ready,
  output logic [7:0] dout,
  output logic [1:0] dout_lsb,
  output logic dout_valid
);

  // weighted sum of three channels, weights sum to 1024, rounded to nearest
  function automatic logic [7:0] f_wsum(input logic [7:0] r, input logic [7:0] g, input logic [7:0] b,
                                        input logic [9:0] kr, input logic [9:0] kg, input logic [9:0] kb);
    logic [19:0] s;
    s = 20'(kr) * 20'(r) + 20'(kg) * 20'(g) + 20'(kb) * 20'(b) + 20'(`POF_RND);
    return s[17:10];
  endfunction

  // gain on (colour - luma), rounded, offset by 128, clamped; optional offset removal
  function automatic logic [7:0] f_chroma(input logic [7:0] c, input logic [7:0] y, input logic [9:0] k,
                                          input logic [7:0] lo, input logic [7:0] hi, input logic nooff);
    logic signed [21:0] p;
    logic signed [21:0] v;
    logic [7:0] q;
    p = (22'(signed'({1'b0, c})) - 22'(signed'({1'b0, y}))) * 22'(signed'({1'b0, k}));
    v = (p + signed'(22'(`POF_RND))) >>> 10;
    v = v + signed'(22'(`POF_C_OFF));
    if (v < signed'(22'(lo)))
      q = lo;
    else if (v > signed'(22'(hi)))
      q = hi;
    else
      q = v[7:0];
    // without the offset the result is a two's complement byte
    if (nooff)
      q = q ^ `POF_SIGN_FLIP;
    return q;
  endfunction

  // studio luma: scale by 219/256, add 16, keep inside 16..235
  function automatic logic [7:0] f_studio(input logic [7:0] y);
    logic [15:0] s;
    logic [7:0] q;
    s = 16'(y) * `POF_Y_SCALE + `POF_SCL_RND;
    q = s[15:8] + `POF_Y_FLOOR;
    if (q > `POF_Y_CEIL)
      q = `POF_Y_CEIL;
    return q;
  endfunction

  // register bus state
  logic [7:0] ctrl_r;          // control register
  logic [11:0] awaddr_r;       // held write address
  logic [31:0] wdata_r;        // held write data
  logic [3:0] wstrb_r;         // held byte enables
  logic aw_have_r;             // write address captured
  logic w_have_r;              // write data captured
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;

  // pixel path state
  logic pix_ready_r;           // a new pixel may be taken
  logic [7:0] dout_r;
  logic [1:0] dout_lsb_r;
  logic dout_valid_r;
  logic pend_r;                // second byte still to send
  logic [7:0] second_r;        // second byte of the pair
  logic phase_r;               // odd pixel of a YCbCr pair
  logic [7:0] hold_r;          // chroma kept for the odd pixel
  logic [15:0] pix_cnt_r;      // pixels taken, wraps

  // control field decode
  wire pof_mode_e mode_w = pof_mode_e'(ctrl_r[`POF_MODE_MSB:`POF_MODE_LSB]);
  wire cswap_w = ctrl_r[`POF_CSWAP_BIT];
  wire ycswap_w = ctrl_r[`POF_YCSWAP_BIT];
  wire nooff_w = ctrl_r[`POF_NOOFF_BIT];
  wire en_w = ctrl_r[`POF_EN_BIT];
  wire accept_w = pix_valid & pix_ready_r;
  wire is_601_w = (mode_w == POF_YUV601);
  wire is_ycc_w = (mode_w == POF_YCC_SRGB);
  wire is_yuv_w = is_601_w | is_ycc_w | (mode_w == POF_YUV_SRGB);

  // luma in both weightings
  wire [7:0] y601_w = f_wsum(pix_i.r, pix_i.g, pix_i.b, `POF_K601_R, `POF_K601_G, `POF_K601_B);
  wire [7:0] ysrgb_w = f_wsum(pix_i.r, pix_i.g, pix_i.b, `POF_KSRGB_R, `POF_KSRGB_G, `POF_KSRGB_B);
  wire [7:0] ybase_w = is_601_w ? y601_w : ysrgb_w;
  wire [7:0] yout_w = is_ycc_w ? f_studio(ysrgb_w) : ybase_w;

  // chroma gains and limits per mode
  wire [9:0] kcb_w = is_601_w ? `POF_K601_U : (is_ycc_w ? `POF_KSTU_CB : `POF_KSRGB_U);
  wire [9:0] kcr_w = is_601_w ? `POF_K601_V : (is_ycc_w ? `POF_KSTU_CR : `POF_KSRGB_V);
  wire [7:0] clo_w = is_ycc_w ? `POF_C_FLOOR : `POF_FULL_LO;
  wire [7:0] chi_w = is_ycc_w ? `POF_C_CEIL : `POF_FULL_HI;
  wire nooff_eff_w = nooff_w & ~is_ycc_w;
  wire [7:0] cb_w = f_chroma(pix_i.b, ybase_w, kcb_w, clo_w, chi_w, nooff_eff_w);
  wire [7:0] cr_w = f_chroma(pix_i.r, ybase_w, kcr_w, clo_w, chi_w, nooff_eff_w);
  wire [7:0] cfirst_w = cswap_w ? cr_w : cb_w;
  wire [7:0] csecond_w = cswap_w ? cb_w : cr_w;
  wire [7:0] ychr_w = phase_r ? hold_r : cfirst_w;

  // red and blue exchange for packed RGB
  wire [7:0] rs_w = cswap_w ? pix_i.b : pix_i.r;
  wire [7:0] bs_w = cswap_w ? pix_i.r : pix_i.b;

  // byte pair of the current pixel, odd byte first before any swap
  logic [7:0] odd_w;
  logic [7:0] even_w;
  logic two_w;
  logic [1:0] lsb_w;

  // per-mode packing
  always_comb
  begin
    odd_w = ychr_w;
    even_w = yout_w;
    two_w = 1'b1;
    lsb_w = 2'h0;
    case (mode_w)
      POF_RGB565:
      begin
        odd_w = {rs_w[7:3], pix_i.g[7:5]};
        even_w = {pix_i.g[4:2], bs_w[7:3]};
      end
      POF_RGB555:
      begin
        odd_w = {1'b0, rs_w[7:3], pix_i.g[7:6]};
        even_w = {pix_i.g[4:2], bs_w[7:3]};
      end
      POF_RGB444X:
      begin
        odd_w = {rs_w[7:4], pix_i.g[7:4]};
        even_w = {bs_w[7:4], 4'h0};
      end
      POF_RGBX444:
      begin
        odd_w = {4'h0, rs_w[7:4]};
        even_w = {pix_i.g[7:4], bs_w[7:4]};
      end
      POF_BAYER10:
      begin
        odd_w = pix_i.raw[9:2];
        lsb_w = pix_i.raw[1:0];
        two_w = 1'b0;
      end
      POF_BAYER82:
      begin
        odd_w = pix_i.raw[9:2];
        even_w = {6'h00, pix_i.raw[1:0]};
      end
      default:
      begin
        // YCbCr: chroma then luma unless swapped below
        odd_w = ychr_w;
        even_w = yout_w;
      end
    endcase
  end

  // luma/chroma swap reverses the pair in every non-Bayer mode
  wire swap_pair_w = ycswap_w & (mode_w != POF_BAYER10) & (mode_w != POF_BAYER82);
  wire [7:0] first_w = swap_pair_w ? even_w : odd_w;
  wire [7:0] second_w = swap_pair_w ? odd_w : even_w;

  // register bus decode
  wire aw_hs_w = s_axi_awvalid & awready_r;
  wire w_hs_w = s_axi_wvalid & wready_r;
  wire ar_hs_w = s_axi_arvalid & arready_r;
  wire wr_go_w = aw_have_r & w_have_r & ~bvalid_r;
  wire wr_ctrl_w = ({awaddr_r[11:2], 2'b00} == `POF_CTRL_OFS);
  wire wr_stat_w = ({awaddr_r[11:2], 2'b00} == `POF_STAT_OFS);
  wire rd_ctrl_w = ({s_axi_araddr[11:2], 2'b00} == `POF_CTRL_OFS);
  wire rd_stat_w = ({s_axi_araddr[11:2], 2'b00} == `POF_STAT_OFS);
  wire busy_w = pend_r | dout_valid_r;
  logic [31:0] stat_w;
  logic [31:0] rmux_w;
  always_comb
  begin
    stat_w = 32'h0000_0000;
    stat_w[`POF_STAT_BUSY] = busy_w;
    stat_w[`POF_STAT_PHASE] = phase_r;
    stat_w[`POF_STAT_CNT_MSB:`POF_STAT_CNT_LSB] = pix_cnt_r;
    if (rd_ctrl_w)
      rmux_w = {24'h00_0000, ctrl_r};
    else if (rd_stat_w)
      rmux_w = stat_w;
    else
      rmux_w = 32'h0000_0000;
  end

  // write channel: address and data taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      awaddr_r <= 12'h000;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end
    else
    begin
      if (aw_hs_w)
      begin
        aw_have_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
        awready_r <= 1'b0;
      end
      else if (s_axi_bready & bvalid_r)
        aw_have_r <= 1'b0;
      else if (!aw_have_r && !bvalid_r)
        awready_r <= 1'b1;
      if (w_hs_w)
      begin
        w_have_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
        wready_r <= 1'b0;
      end
      else if (s_axi_bready & bvalid_r)
        w_have_r <= 1'b0;
      else if (!w_have_r && !bvalid_r)
        wready_r <= 1'b1;
    end
  end

  // write response and control register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_r <= 1'b0;
      bresp_r <= `POF_RESP_OKAY;
      ctrl_r <= `POF_CTRL_RST;
    end
    else if (wr_go_w)
    begin
      bvalid_r <= 1'b1;
      bresp_r <= (wr_ctrl_w | wr_stat_w) ? `POF_RESP_OKAY : `POF_RESP_SLVERR;
      if (wr_ctrl_w && wstrb_r[0])
        ctrl_r <= wdata_r[7:0];
    end
    else if (s_axi_bready)
      bvalid_r <= 1'b0;
  end

  // read channel: one read at a time, data registered with the response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rresp_r <= `POF_RESP_OKAY;
      rdata_r <= 32'h0000_0000;
    end
    else if (ar_hs_w)
    begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= rmux_w;
      rresp_r <= (rd_ctrl_w | rd_stat_w) ? `POF_RESP_OKAY : `POF_RESP_SLVERR;
    end
    else if (rvalid_r && s_axi_rready)
      rvalid_r <= 1'b0;
    else if (!rvalid_r)
      arready_r <= 1'b1;
  end

  // byte sequencer: first byte on the edge a pixel is taken, second on the next
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pix_ready_r <= 1'b0;
      dout_r <= 8'h00;
      dout_lsb_r <= 2'h0;
      dout_valid_r <= 1'b0;
      pend_r <= 1'b0;
      second_r <= 8'h00;
      phase_r <= 1'b0;
      hold_r <= 8'h00;
      pix_cnt_r <= 16'h0000;
    end
    else if (accept_w)
    begin
      dout_r <= first_w;
      dout_lsb_r <= lsb_w;
      dout_valid_r <= 1'b1;
      pend_r <= two_w;
      second_r <= second_w;
      pix_ready_r <= ~two_w & en_w;
      phase_r <= is_yuv_w & ~phase_r;
      hold_r <= csecond_w;
      pix_cnt_r <= pix_cnt_r + 16'h0001;
    end
    else if (pend_r)
    begin
      dout_r <= second_r;
      dout_lsb_r <= 2'h0;
      dout_valid_r <= 1'b1;
      pend_r <= 1'b0;
      pix_ready_r <= en_w;
    end
    else
    begin
      dout_valid_r <= 1'b0;
      pix_ready_r <= en_w;
      if (!en_w)
        phase_r <= 1'b0;
    end
  end

  // gray input in full-range YUV gives the gray value as luma
  a_gray_luma: assert property (@(posedge aclk) disable iff (!aresetn)
    accept_w && (is_601_w || mode_w == POF_YUV_SRGB) && !ycswap_w && !phase_r
      && pix_i.r == pix_i.g && pix_i.g == pix_i.b |-> ##2 dout_valid_r && dout_r == $past(pix_i.g, 2))
    else $error("full-range luma of gray input is wrong");

  // gray input gives chroma 128, or 0 without offset
  a_gray_chroma: assert property (@(posedge aclk) disable iff (!aresetn)
    accept_w && (is_601_w || mode_w == POF_YUV_SRGB) && !ycswap_w && !phase_r
      && pix_i.r == pix_i.g && pix_i.g == pix_i.b |=> dout_r == ($past(nooff_w) ? 8'h00 : 8'h80))
    else $error("chroma of gray input is wrong");

  // studio mode bytes stay within the studio range
  a_studio_range: assert property (@(posedge aclk) disable iff (!aresetn)
    accept_w && is_ycc_w |=> dout_r >= 8'h10 && dout_r <= 8'hF0 ##1 dout_r >= 8'h10 && dout_r <= 8'hF0)
    else $error("studio output outside range");

  // studio luma never above 235
  a_studio_luma: assert property (@(posedge aclk) disable iff (!aresetn)
    accept_w && is_ycc_w && !ycswap_w |-> ##2 dout_r <= 8'hEB)
    else $error("studio luma above ceiling");

  // odd pixel carries held chroma, swapped order puts luma first
  a_ycc_order: assert property (@(posedge aclk) disable iff (!aresetn)
    accept_w && is_yuv_w && ycswap_w |=> dout_r == $past(yout_w) ##1 dout_r == $past(ychr_w, 2))
    else $error("YCbCr byte order wrong under swap");

  // 565 packing without swaps
  a_pack_565: assert property (@(posedge aclk) disable iff (!aresetn)
    accept_w && mode_w == POF_RGB565 && !ycswap_w && !cswap_w
      |=> dout_r == {$past(pix_i.r[7:3]), $past(pix_i.g[7:5])}
      ##1 dout_r == {$past(pix_i.g[4:2], 2), $past(pix_i.b[7:3], 2)})
    else $error("565 packing wrong");

  // swaps on 565: bytes reversed, red and blue exchanged
  a_swap_565: assert property (@(posedge aclk) disable iff (!aresetn)
    accept_w && mode_w == POF_RGB565 && ycswap_w && cswap_w
      |=> dout_r == {$past(pix_i.g[4:2]), $past(pix_i.r[7:3])})
    else $error("565 swap wrong");

  // 555 and x444: zero top bit, then blue (red when chroma swapped) ends the even byte
  a_pack_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    accept_w && !ycswap_w && (mode_w == POF_RGB555 || mode_w == POF_RGBX444)
      |=> dout_r[7] == 1'b0 ##1 ($past(mode_w, 2) == POF_RGB555
        ? dout_r[4:0] == $past(cswap_w ? pix_i.r[7:3] : pix_i.b[7:3], 2)
        : dout_r[3:0] == $past(cswap_w ? pix_i.r[7:4] : pix_i.b[7:4], 2)))
    else $error("555 or x444 packing wrong");

  // 444x even byte ends in four zeros
  a_pack_444x: assert property (@(posedge aclk) disable iff (!aresetn)
    accept_w && mode_w == POF_RGB444X && !ycswap_w |-> ##2 dout_r[3:0] == 4'h0)
    else $error("444x even byte wrong");

  // ten-wire Bayer: one byte per sample, low bits on the side bus
  a_bayer_10: assert property (@(posedge aclk) disable iff (!aresetn)
    accept_w && mode_w == POF_BAYER10 |=> dout_valid_r && !pend_r
      && {dout_r, dout_lsb_r} == $past(pix_i.raw))
    else $error("ten-wire Bayer output wrong");

  // 8+2 Bayer: high byte then padded low bits
  a_bayer_82: assert property (@(posedge aclk) disable iff (!aresetn)
    accept_w && mode_w == POF_BAYER82 |=> dout_r == $past(pix_i.raw[9:2])
      ##1 dout_valid_r && dout_r == {6'h00, $past(pix_i.raw[1:0], 2)} && dout_lsb_r == 2'h0)
    else $error("8+2 Bayer output wrong");

  // ports straight from flip-flops
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign pix_ready = pix_ready_r;
  assign dout = dout_r;
  assign dout_lsb = dout_lsb_r;
  assign dout_valid = dout_valid_r;

endmodule

// file: tb/pof_host_cap.sv
`timescale 1ns/1ps
// host side of the pixel bus: captures every flagged byte, never stalls
module pof_host_cap
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] dout,
  input wire logic [1:0] dout_lsb,
  input wire logic dout_valid
);
  // captured words, two-wire bus above the byte
  logic [9:0] q[$];

  // round to nearest inside 0..255
  function automatic logic [7:0] lim(input real x);
    if (x < 0.0)
      x = 0.0;
    if (x > 255.0)
      x = 255.0;
    return 8'(int'(x));
  endfunction

  // receiver recovery of colour from full-range sRGB luma and chroma
  function automatic logic [23:0] to_rgb(input logic [7:0] y, input logic [7:0] u, input logic [7:0] v);
    real r, g, b;
    r = y + 1.5748 * (v - 128.0);
    g = y - 0.1873 * (u - 128.0) - 0.4681 * (v - 128.0);
    b = y + 1.8556 * (u - 128.0);
    return {lim(r), lim(g), lim(b)};
  endfunction

  // host samples the bus on each rising edge that flags a byte
  always @(posedge aclk)
  begin
    if (aresetn && dout_valid)
      q.push_back({dout_lsb, dout});
  end
endmodule

// file: tb/testbench.sv
`timescale 1ns/1ps
`include "pof_regs.svh"
module testbench
  import pof_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic [11:0] s_axi_araddr = 12'h000;
  logic [2:0] s_axi_awprot = 3'h0;
  logic [2:0] s_axi_arprot = 3'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  pof_pix_s pix_i = '0;
  logic pix_valid = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pix_ready, dout_valid;
  logic [1:0] s_axi_bresp, s_axi_rresp, dout_lsb;
  logic [31:0] s_axi_rdata;
  logic [7:0] dout;
  int n_mismatch = 0;
  int n_checks = 0;
  int n_pix = 0;
  // expected bytes and their offset-dropped flags
  logic [9:0] eq[$];
  bit fq[$];

  // 40 MHz clock
  initial
  begin
    forever #12.5 aclk = ~aclk;
  end

  pof_top dut(.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .pix_i, .pix_valid, .pix_ready, .dout, .dout_lsb, .dout_valid);
  pof_host_cap cap(.aclk, .aresetn, .dout, .dout_lsb, .dout_valid);

  // verdict and end of run
  task summarize;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // exact comparison
  task chk_eq(input logic [9:0] got, input logic [9:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // comparison allowing one step of rounding difference
  task chk_near(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if ((^got === 1'bx) || ((got - exp + 8'h01) > 8'h02))
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // recovered colour, allowing rounding in both directions of the conversion
  task chk_rgb(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if ((^got === 1'bx) || ((got - exp + 8'h04) > 8'h08))
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one write: address and data offered together, each released when taken
  task bus_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] resp);
    int t;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    t = 0;
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      t++;
    end while (s_axi_bvalid !== 1'b1 && t < 200);
    s_axi_bready <= 1'b0;
    resp = s_axi_bresp;
    if (t == 200)
      n_mismatch++;
  endtask

  // one read: address held until taken, data taken with rvalid
  task bus_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] resp);
    int t;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    t = 0;
    do
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      t++;
    end while (s_axi_rvalid !== 1'b1 && t < 200);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    resp = s_axi_rresp;
    if (t == 200)
      n_mismatch++;
  endtask

  // offer one pixel and hold it until the block takes it; valid stays up
  task send_pix(input pof_pix_s p);
    int t;
    pix_i <= p;
    pix_valid <= 1'b1;
    t = 0;
    do
    begin
      @(posedge aclk);
      t++;
    end while (pix_ready !== 1'b1 && t < 100);
    n_pix++;
  endtask

  // expected byte with its offset-dropped flag
  task put(input logic [9:0] v, input bit f);
    eq.push_back(v);
    fq.push_back(f);
  endtask

  // round to nearest and clamp
  function automatic logic [7:0] rc(input real v, input real lo, input real hi);
    if (v < lo)
      v = lo;
    if (v > hi)
      v = hi;
    return 8'(int'(v));
  endfunction

  // colour conversion for modes 0..2, packed as luma, blue diff, red diff
  function automatic logic [23:0] yuv(input int m, input pof_pix_s p);
    real r, g, b, y, u, v, k, lo, hy, hc;
    r = p.r;
    g = p.g;
    b = p.b;
    k = (m == 1) ? 0.875 : 1.0;
    lo = (m == 1) ? 16.0 : 0.0;
    hy = (m == 1) ? 235.0 : 255.0;
    hc = (m == 1) ? 240.0 : 255.0;
    y = (m == 0) ? 0.299 * r + 0.587 * g + 0.114 * b : 0.2126 * r + 0.7152 * g + 0.0722 * b;
    u = (m == 0) ? 0.564 * (b - y) : 0.5389 * (b - y) * k;
    v = (m == 0) ? 0.713 * (r - y) : 0.635 * (r - y) * k;
    if (m == 1)
      y = y * 219.0 / 256.0 + 16.0;
    return {rc(y, lo, hy), rc(u + 128.0, lo, hc), rc(v + 128.0, lo, hc)};
  endfunction

  // rgb word, odd byte in the upper half
  function automatic logic [15:0] rgb(input int m, input logic [7:0] r, input logic [7:0] g, input logic [7:0] b);
    case (m)
      3: return {r[7:3], g[7:2], b[7:3]};
      4: return {1'b0, r[7:3], g[7:6], g[4:2], b[7:3]};
      5: return {r[7:4], g[7:4], b[7:4], 4'h0};
      default: return {4'h0, r[7:4], g[7:4], b[7:4]};
    endcase
  endfunction

  // watchdog far beyond the expected run length
  initial
  begin
    repeat (40000) @(posedge aclk);
    $display("watchdog expired");
    n_mismatch++;
    summarize();
  end

  // main sequence
  initial
  begin
    logic [1:0] resp;
    logic [31:0] rd;
    logic [23:0] c0, c1;
    logic [7:0] ca, cb;
    logic [15:0] w;
    logic [9:0] got;
    logic [7:0] gb [8];
    logic [23:0] back;
    int nb, fi, si;
    pof_pix_s px [4];
    pof_pix_s cp [4] = '{'{8'hFF, 8'h00, 8'h00, 10'h3FF}, '{8'h00, 8'h00, 8'hFF, 10'h000},
      '{8'hFF, 8'hFF, 8'hFF, 10'h155}, '{8'h00, 8'h00, 8'h00, 10'h2AA}};
    void'($urandom(32'h17A9BA42));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    // register reset value, unmapped read and write, status write ignored
    bus_rd(`POF_CTRL_OFS, rd, resp);
    chk_eq(rd[9:0], {2'b00, `POF_CTRL_RST});
    chk_eq({8'h00, resp}, {8'h00, `POF_RESP_OKAY});
    bus_rd(12'h010, rd, resp);
    chk_eq({8'h00, resp}, {8'h00, `POF_RESP_SLVERR});
    chk_eq(rd[9:0], 10'h000);
    bus_wr(12'h010, 32'h0000_00FF, resp);
    chk_eq({8'h00, resp}, {8'h00, `POF_RESP_SLVERR});
    bus_wr(`POF_STAT_OFS, 32'h0000_00FF, resp);
    chk_eq({8'h00, resp}, {8'h00, `POF_RESP_OKAY});
    bus_rd(`POF_CTRL_OFS, rd, resp);
    chk_eq(rd[9:0], 10'h000);
    bus_rd(`POF_STAT_OFS, rd, resp);
    chk_eq(rd[9:0], 10'h000);
    chk_eq({8'h00, resp}, {8'h00, `POF_RESP_OKAY});
    $display("test registers done");
    // every mode under every swap combination, corner pixels then random ones
    for (int m = 0; m <= 8; m++)
      for (int cs = 0; cs < 2; cs++)
        for (int yc = 0; yc < 2; yc++)
          for (int no = 0; no <= ((m == 0 || m == 2) ? 1 : 0); no++)
          begin
            bus_wr(`POF_CTRL_OFS, 32'h0, resp);
            bus_wr(`POF_CTRL_OFS, {24'h0, 1'b1, no[0], yc[0], cs[0], m[3:0]}, resp);
            for (int rnd = 0; rnd < 2; rnd++)
            begin
              for (int k = 0; k < 4; k++)
                px[k] = rnd ? pof_pix_s'(34'({$urandom(), $urandom()})) : cp[k];
              for (int k = 0; k < 4; k++)
                send_pix(px[k]);
              pix_valid <= 1'b0;
              for (int k = 0; k < 4; k++)
              begin
                if (m < 3 && k[0] == 1'b0)
                begin
                  c0 = yuv(m, px[k]);
                  c1 = yuv(m, px[k + 1]);
                  ca = cs ? c0[7:0] : c0[15:8];
                  cb = cs ? c0[15:8] : c0[7:0];
                  if (yc)
                  begin
                    put({2'b00, c0[23:16]}, 1'b0);
                    put({2'b00, ca}, no[0]);
                    put({2'b00, c1[23:16]}, 1'b0);
                    put({2'b00, cb}, no[0]);
                  end
                  else
                  begin
                    put({2'b00, ca}, no[0]);
                    put({2'b00, c0[23:16]}, 1'b0);
                    put({2'b00, cb}, no[0]);
                    put({2'b00, c1[23:16]}, 1'b0);
                  end
                end
                else if (m >= 3 && m <= 6)
                begin
                  w = rgb(m, cs ? px[k].b : px[k].r, px[k].g, cs ? px[k].r : px[k].b);
                  put({2'b00, yc ? w[7:0] : w[15:8]}, 1'b0);
                  put({2'b00, yc ? w[15:8] : w[7:0]}, 1'b0);
                end
                else if (m == 7)
                  put({px[k].raw[1:0], px[k].raw[9:2]}, 1'b0);
                else if (m == 8)
                begin
                  put({2'b00, px[k].raw[9:2]}, 1'b0);
                  put({8'h00, px[k].raw[1:0]}, 1'b0);
                end
              end
              for (int t = 0; t < 100 && cap.q.size() < eq.size(); t++)
                @(posedge aclk);
              nb = 0;
              while (eq.size() > 0)
              begin
                got = cap.q.pop_front();
                gb[nb] = got[7:0];
                nb++;
                if (m < 3)
                  chk_near(fq[0] ? got[7:0] ^ 8'h80 : got[7:0], eq[0][7:0]);
                else
                  chk_eq(got, eq[0]);
                void'(eq.pop_front());
                void'(fq.pop_front());
              end
              // receiver recovers the even pixel of each pair from captured bytes
              if (m == 2 && no == 0)
                for (int j = 0; j < 8; j += 4)
                begin
                  fi = yc ? j + 1 : j;
                  si = yc ? j + 3 : j + 2;
                  back = cap.to_rgb(gb[yc ? j : j + 1], gb[cs ? si : fi], gb[cs ? fi : si]);
                  chk_rgb(back[23:16], px[j / 2].r);
                  chk_rgb(back[15:8], px[j / 2].g);
                  chk_rgb(back[7:0], px[j / 2].b);
                end
              chk_eq(10'(cap.q.size()), 10'h000);
            end
          end
    // status: pixel count and idle flags after the last format
    bus_rd(`POF_STAT_OFS, rd, resp);
    chk_eq(rd[25:16], 10'(n_pix));
    chk_eq({8'h00, rd[1:0]}, 10'h000);
    $display("test formats done");
    summarize();
  end
endmodule
